// ==== verilog/startup_seq_pkg.sv ====
// Purpose: shared constants and carrier types for the led driver startup sequencer
// Assumes: 50 MHz clock_in; analog comparators arrive as asynchronous levels
// Notes: times are kept in their printed unit, cycle counts derive from them
package startup_seq_pkg;

    localparam int CLOCK_HZ = 50000000; // system clock rate
    localparam int NUM_CHANNELS = 6; // led current sinks

    // sequencing times in microseconds
    localparam int SHUTDOWN_DELAY_US = 16000; // wake low filter
    localparam int DETECT_WAIT_US = 1500; // led pin settle wait
    localparam int SOFT_START_US = 16000; // soft-start timer
    localparam int LATCH_CLEAR_US = 16000; // dimming low latch clear filter

    // derived cycle counts
    localparam int SHUTDOWN_DELAY_CYC = (CLOCK_HZ / 1000000) * SHUTDOWN_DELAY_US;
    localparam int DETECT_WAIT_CYC = (CLOCK_HZ / 1000000) * DETECT_WAIT_US;
    localparam int SOFT_START_CYC = (CLOCK_HZ / 1000000) * SOFT_START_US;
    localparam int LATCH_CLEAR_CYC = (CLOCK_HZ / 1000000) * LATCH_CLEAR_US;

    localparam int TIMER_WIDTH = 24; // wide enough for 800000 cycles

    // sequencer states
    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_GATE_PULL = 3'h1,
        ST_WAIT_DIM = 3'h2,
        ST_DETECT = 3'h3,
        ST_SOFT_START = 3'h4,
        ST_RUN = 3'h5,
        ST_LATCHED = 3'h6
    } seq_state_type;

    // per-channel led pin comparator levels
    typedef struct packed {
        logic above_short; // above short threshold (~120 mV)
        logic above_in_use; // above in-use threshold (~340 mV)
        logic in_regulation; // sink at regulation current
    } led_sense_type;

    // power-up check comparators
    typedef struct packed {
        logic output_shorted; // output shorted to ground
        logic frequency_set_pin_fault; // frequency set pin open or shorted
        logic current_set_pin_fault; // current set pin open or shorted
        logic output_above_uv; // sensed output above overvoltage level / 12
        logic output_at_93pct; // output at 93% of overvoltage threshold
        logic gate_pulled; // disconnect gate at supply minus 3.3 V
    } power_sense_type;

endpackage : startup_seq_pkg

// ==== verilog/hold_timer.sv ====
// Purpose: counts cycles while a qualifying level holds, flags expiry
// Assumes: condition is already synchronous to clock_in
// Notes: restarts from zero whenever the condition drops
`timescale 1ns/1ns
module hold_timer #(
    parameter int LIMIT = 800000,
    parameter int WIDTH = 24
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // condition and result
    input wire logic hold_in,
    output logic expired_out
);
    import startup_seq_pkg::*;

    localparam logic [WIDTH-1:0] LAST = WIDTH'(LIMIT - 1); // terminal count

    logic [WIDTH-1:0] count_reg; // cycles the condition has held

    // count up while held, saturate at the terminal count, clear when released
    always_ff @(posedge clock_in) begin
        if (srst_in || !hold_in) begin
            count_reg <= '0; // R21
            expired_out <= 1'b0;
        end else if (count_reg == LAST) begin
            expired_out <= 1'b1;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

endmodule : hold_timer

// ==== verilog/led_startup_sequencer.sv ====
// Purpose: startup and fault sequencer of a six-channel led boost driver
// Assumes: all sense inputs are asynchronous levels and are synchronised here
// Notes: the host drives wake and dimming gate; they may be tied together
// Summary of operation
// R1: wake needs wake input and supply above lockout
// R2: boost and channels enabled only by dimming gate
// R3: power-up checks must pass before switching
// R4: wake low over 16 ms shuts off
// R5: detection needs dimming gate and pulled gate
// R6: wait 1.5 ms after pins exceed 120 mV
// R7: classify pins as short, unused, in use
// R8: unused channels excluded from regulation loop
// R9: short faults drive fault low, retry
// R10: led short fault released at detection end
// R11: output undervoltage blocks soft-start
// R12: undervoltage fault latches device off
// R13: latch clears on lockout or wake low
// R14: latch clears on dimming low 16 ms
// R15: soft-start ends at first of three events
// R16: soft-start follows detection, 16 ms timer
// R17: wake ramps regulator, clock out, gate pull
// R18: gate reached enables current reference, await dimming
// R19: host may tie wake and dimming together
// R20: wait 1.5 ms short test before soft-start
// R21: timers clocked internally, reset when condition ends
`timescale 1ns/1ns
module led_startup_sequencer #(
    parameter int CHANNELS = startup_seq_pkg::NUM_CHANNELS,
    parameter int SHUTDOWN_CYC = startup_seq_pkg::SHUTDOWN_DELAY_CYC,
    parameter int DETECT_CYC = startup_seq_pkg::DETECT_WAIT_CYC,
    parameter int SOFT_CYC = startup_seq_pkg::SOFT_START_CYC,
    parameter int CLEAR_CYC = startup_seq_pkg::LATCH_CLEAR_CYC
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // host inputs
    input wire logic wake_in,
    input wire logic dim_gate_in,
    // supply monitor
    input wire logic supply_ok_in,
    // analog sense levels
    input wire startup_seq_pkg::power_sense_type power_sense_in,
    input wire startup_seq_pkg::led_sense_type [CHANNELS-1:0] led_sense_in,
    // power control outputs
    output logic regulator_on_out,
    output logic clock_output_en_out,
    output logic gate_pull_out,
    output logic current_ref_en_out,
    output logic boost_en_out,
    output logic soft_start_out,
    // channel outputs
    output logic [CHANNELS-1:0] channel_en_out,
    // status outputs
    output logic fault_n_out,
    output logic output_undervoltage_fault_out,
    output startup_seq_pkg::seq_state_type state_out
);
    import startup_seq_pkg::*;

    // two-flop synchronisers, first stage read only by the second
    // host pins and supply monitor
    logic [2:0] host_meta_reg;
    logic [2:0] host_sync_reg;
    // power-up check comparators
    power_sense_type power_meta_reg;
    power_sense_type power_sync_reg;
    // per-channel pin comparators
    led_sense_type [CHANNELS-1:0] led_meta_reg;
    led_sense_type [CHANNELS-1:0] led_sync_reg;

    // synchronised names
    logic wake;
    logic dim_gate;
    logic supply_ok;

    seq_state_type state_reg; // sequencer state
    seq_state_type state_next;
    logic [CHANNELS-1:0] used_reg; // channels found in use
    logic uv_latch_reg; // latched output undervoltage
    logic uv_latch_next; // latch value after this edge
    logic led_short_reg; // led short seen in current detection
    logic settle_start_reg; // pins have risen above short level

    // timer results
    logic shutdown_expired;
    logic detect_expired;
    logic soft_expired;
    logic clear_expired;

    // derived conditions
    logic any_short;
    logic all_regulating;
    logic pin_fault;
    logic soft_done;
    logic led_short_live; // led short as it stands after this edge
    logic boosting; // boost stage allowed after this edge

    // pick out the synchronised host levels
    assign wake = host_sync_reg[0];
    assign dim_gate = host_sync_reg[1];
    assign supply_ok = host_sync_reg[2];

    // synchronise every asynchronous input
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            host_meta_reg <= 3'h0;
            host_sync_reg <= 3'h0;
            power_meta_reg <= '0;
            power_sync_reg <= '0;
            led_meta_reg <= '0;
            led_sync_reg <= '0;
        end else begin
            host_meta_reg <= {supply_ok_in, dim_gate_in, wake_in};
            host_sync_reg <= host_meta_reg;
            power_meta_reg <= power_sense_in;
            power_sync_reg <= power_meta_reg;
            led_meta_reg <= led_sense_in;
            led_sync_reg <= led_meta_reg;
        end
    end

    // channel condition reduction
    always_comb begin
        any_short = 1'b0;
        all_regulating = 1'b1;
        for (int i = 0; i < CHANNELS; i++) begin
            if (!led_sync_reg[i].above_short) begin
                any_short = 1'b1; // R7
            end
            if (used_reg[i] && !led_sync_reg[i].in_regulation) begin
                all_regulating = 1'b0;
            end
        end
    end

    // power-up pin checks
    assign pin_fault = power_sync_reg.output_shorted || power_sync_reg.frequency_set_pin_fault
        || power_sync_reg.current_set_pin_fault; // R3

    // soft-start completes at the first of its three ends
    assign soft_done = all_regulating || power_sync_reg.output_at_93pct || soft_expired; // R15

    // wake low filter, shuts down and clears latch
    hold_timer #(.LIMIT(SHUTDOWN_CYC), .WIDTH(TIMER_WIDTH)) shutdown_timer (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .hold_in(!wake), // R4
        .expired_out(shutdown_expired)
    );

    // detection settle wait after pins rise
    hold_timer #(.LIMIT(DETECT_CYC), .WIDTH(TIMER_WIDTH)) detect_timer (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .hold_in(state_reg == ST_DETECT && settle_start_reg), // R6
        .expired_out(detect_expired)
    );

    // soft-start ramp timer
    hold_timer #(.LIMIT(SOFT_CYC), .WIDTH(TIMER_WIDTH)) soft_timer (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .hold_in(state_reg == ST_SOFT_START), // R16
        .expired_out(soft_expired)
    );

    // dimming low with wake high while latched, clears latch and restarts at gate pull
    hold_timer #(.LIMIT(CLEAR_CYC), .WIDTH(TIMER_WIDTH)) clear_timer (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .hold_in(wake && !dim_gate && state_reg == ST_LATCHED), // R14
        .expired_out(clear_expired)
    );

    // next state
    always_comb begin
        // stay put unless a transition below fires
        state_next = state_reg;
        unique case (state_reg)
            // asleep until wake and supply
            ST_OFF: begin
                if (wake && supply_ok) begin
                    state_next = ST_GATE_PULL; // R1
                end
            end
            // disconnect gate pulling down slowly
            ST_GATE_PULL: begin
                if (power_sync_reg.gate_pulled) begin
                    state_next = ST_WAIT_DIM; // R18
                end
            end
            // reference on, waiting for the dimming gate
            ST_WAIT_DIM: begin
                if (dim_gate && power_sync_reg.gate_pulled && !pin_fault) begin
                    state_next = ST_DETECT; // R5
                end
            end
            // classify pins and check the output
            ST_DETECT: begin
                if (!power_sync_reg.output_above_uv && settle_start_reg) begin
                    state_next = ST_LATCHED; // R11
                end else if (detect_expired && !any_short && !pin_fault) begin
                    state_next = ST_SOFT_START; // R20
                end
            end
            // ramping the output
            ST_SOFT_START: begin
                if (!power_sync_reg.output_above_uv) begin
                    state_next = ST_LATCHED; // R12
                end else if (soft_done) begin
                    state_next = ST_RUN;
                end
            end
            // regulating
            ST_RUN: begin
                if (!power_sync_reg.output_above_uv) begin
                    state_next = ST_LATCHED; // R12
                end
            end
            // off until the latch clears
            ST_LATCHED: begin
                if (clear_expired) begin
                    state_next = ST_GATE_PULL; // R14
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
        // lockout or long wake low ends everything
        if (!supply_ok || shutdown_expired) begin
            state_next = ST_OFF; // R13
        end
        // dimming low before running returns to waiting
        if ((state_reg == ST_DETECT || state_reg == ST_SOFT_START) && !dim_gate && supply_ok
            && !shutdown_expired) begin
            state_next = ST_WAIT_DIM; // R2
        end
    end

    // state register
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // pins above short level start the settle wait
    always_ff @(posedge clock_in) begin
        if (srst_in || state_reg != ST_DETECT) begin
            settle_start_reg <= 1'b0;
        end else if (!any_short) begin
            settle_start_reg <= 1'b1; // R6
        end
    end

    // led short fault stays until detection ends cleanly
    always_ff @(posedge clock_in) begin
        if (srst_in || state_reg == ST_OFF) begin
            led_short_reg <= 1'b0;
        end else if (state_reg == ST_DETECT && any_short) begin
            led_short_reg <= 1'b1; // R9
        end else if (state_reg == ST_DETECT && state_next == ST_SOFT_START) begin
            led_short_reg <= 1'b0; // R10
        end
    end

    // channel classification at end of detection
    always_ff @(posedge clock_in) begin
        if (srst_in || state_reg == ST_OFF) begin
            used_reg <= '0;
        end else if (state_reg == ST_DETECT && state_next == ST_SOFT_START) begin
            // a pin above the in-use level keeps its channel
            for (int i = 0; i < CHANNELS; i++) begin
                used_reg[i] <= led_sync_reg[i].above_in_use; // R8
            end
        end
    end

    // undervoltage latch next value, set wins over clear
    always_comb begin
        uv_latch_next = uv_latch_reg; // hold by default
        // a new fault outranks a clear in the same cycle
        if (state_next == ST_LATCHED) begin
            uv_latch_next = 1'b1; // R12
        end else if (state_next == ST_OFF || clear_expired) begin
            uv_latch_next = 1'b0; // R13 R14
        end
    end

    // undervoltage latch register
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            uv_latch_reg <= 1'b0;
        end else begin
            uv_latch_reg <= uv_latch_next;
        end
    end

    // led short stays shown until detection hands over to soft-start
    assign led_short_live = (led_short_reg && state_next != ST_SOFT_START)
        || (state_next == ST_DETECT && any_short); // R10

    // boost and channels only with dimming gate high while ramping or running
    assign boosting = dim_gate && (state_next == ST_SOFT_START || state_next == ST_RUN); // R2

    // registered outputs
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            regulator_on_out <= 1'b0;
            clock_output_en_out <= 1'b0;
            gate_pull_out <= 1'b0;
            current_ref_en_out <= 1'b0;
            boost_en_out <= 1'b0;
            soft_start_out <= 1'b0;
            channel_en_out <= '0;
            fault_n_out <= 1'b1;
            output_undervoltage_fault_out <= 1'b0;
            state_out <= ST_OFF;
        end else begin
            // power rails and gate
            regulator_on_out <= state_next != ST_OFF; // R17
            clock_output_en_out <= state_next != ST_OFF; // R17
            gate_pull_out <= state_next != ST_OFF && state_next != ST_LATCHED; // R17
            current_ref_en_out <= state_next inside {ST_WAIT_DIM, ST_DETECT, ST_SOFT_START, ST_RUN}; // R18
            // boost path
            boost_en_out <= boosting; // R2
            soft_start_out <= state_next == ST_SOFT_START; // R16
            // classified channels join one cycle after detection ends
            channel_en_out <= (boosting && state_reg != ST_DETECT) ? used_reg : '0; // R8
            // status follows the values that hold after this edge
            fault_n_out <= !(led_short_live || pin_fault || uv_latch_next); // R9
            output_undervoltage_fault_out <= uv_latch_next; // R12
            state_out <= state_next;
        end
    end

endmodule : led_startup_sequencer

// ==== sim/led_startup_sequencer_chk.sv ====
// Purpose: port assertions for the led startup sequencer
// Assumes: a pin change reaches the state three edges later
// Notes: helper counters time held levels and state dwell
`timescale 1ns/1ns
module led_startup_sequencer_chk #(
    parameter int CHANNELS = startup_seq_pkg::NUM_CHANNELS,
    parameter int SHUTDOWN_CYC = startup_seq_pkg::SHUTDOWN_DELAY_CYC,
    parameter int DETECT_CYC = startup_seq_pkg::DETECT_WAIT_CYC,
    parameter int SOFT_CYC = startup_seq_pkg::SOFT_START_CYC
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // watched inputs
    input wire logic wake_in,
    input wire logic supply_ok_in,
    input wire logic dim_gate_in,
    input wire startup_seq_pkg::power_sense_type power_sense_in,
    // watched outputs
    input wire logic regulator_on_out,
    input wire logic clock_output_en_out,
    input wire logic gate_pull_out,
    input wire logic current_ref_en_out,
    input wire logic boost_en_out,
    input wire logic soft_start_out,
    input wire logic [CHANNELS-1:0] channel_en_out,
    input wire logic fault_n_out,
    input wire logic output_undervoltage_fault_out,
    input wire startup_seq_pkg::seq_state_type state_out
);
    import startup_seq_pkg::*;
    int low_cnt; // cycles wake held low
    int det_cnt; // cycles spent in detection
    int soft_cnt; // cycles spent in soft-start
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);
    // wake low duration
    always_ff @(posedge clock_in) begin
        low_cnt <= (srst_in || wake_in) ? 0 : low_cnt + 1;
    end
    // detection dwell
    always_ff @(posedge clock_in) begin
        det_cnt <= (!srst_in && state_out == ST_DETECT) ? det_cnt + 1 : 0;
    end
    // soft-start dwell
    always_ff @(posedge clock_in) begin
        soft_cnt <= (!srst_in && state_out == ST_SOFT_START) ? soft_cnt + 1 : 0;
    end
    a_wake_gated: assert property ((state_out == ST_GATE_PULL && $past(state_out) == ST_OFF) |->
        $past(wake_in, 3) && $past(supply_ok_in, 3)) else $error("woke without wake and supply");
    a_boost_dim: assert property (boost_en_out |-> $past(dim_gate_in, 3) &&
        (state_out == ST_SOFT_START || state_out == ST_RUN)) else $error("boost without dimming gate");
    a_pin_fault: assert property (($past(power_sense_in.current_set_pin_fault, 3) && state_out != ST_OFF
        && $past(state_out) != ST_OFF && $past(state_out, 2) != ST_OFF) |-> !fault_n_out)
        else $error("set pin fault not flagged");
    a_shutdown_time: assert property (low_cnt > SHUTDOWN_CYC + 4 |-> state_out == ST_OFF)
        else $error("wake low did not shut off");
    a_detect_wait: assert property ((state_out == ST_SOFT_START && $past(state_out) == ST_DETECT)
        |-> det_cnt >= DETECT_CYC) else $error("detection wait too short");
    a_soft_uv: assert property ($rose(soft_start_out) |-> $past(power_sense_in.output_above_uv, 3))
        else $error("soft-start with output undervoltage");
    a_latch_off: assert property (state_out == ST_LATCHED |-> output_undervoltage_fault_out &&
        !boost_en_out && !gate_pull_out && channel_en_out == '0) else $error("latched state not off");
    a_soft_bound: assert property (soft_cnt <= SOFT_CYC + 4) else $error("soft-start overran");
    a_wake_power: assert property (regulator_on_out == (state_out != ST_OFF) &&
        clock_output_en_out == regulator_on_out) else $error("regulator or clock out wrong");
    a_ref_gate: assert property ($rose(current_ref_en_out) |-> state_out == ST_WAIT_DIM &&
        $past(power_sense_in.gate_pulled, 3)) else $error("reference before gate pulled");
    c_soft: cover property ($rose(soft_start_out));
    c_latch: cover property (state_out == ST_LATCHED);
    c_run: cover property (state_out == ST_RUN && $past(state_out) == ST_SOFT_START);
endmodule : led_startup_sequencer_chk

bind led_startup_sequencer led_startup_sequencer_chk #(.CHANNELS(CHANNELS), .SHUTDOWN_CYC(SHUTDOWN_CYC),
    .DETECT_CYC(DETECT_CYC), .SOFT_CYC(SOFT_CYC)) led_startup_sequencer_chk_inst (.clock_in, .srst_in,
    .wake_in, .supply_ok_in, .dim_gate_in, .power_sense_in, .regulator_on_out, .clock_output_en_out,
    .gate_pull_out, .current_ref_en_out, .boost_en_out, .soft_start_out, .channel_en_out, .fault_n_out,
    .output_undervoltage_fault_out, .state_out);

// ==== sim/host_model.sv ====
// Purpose: host driving the wake and dimming gate pins
// Assumes: bench requests change at the falling edge
// Notes: tie mode joins the dimming gate to wake for one-wire control
`timescale 1ns/1ns
module host_model (
    // bench requests
    input wire logic wake_req_in,
    input wire logic dim_req_in,
    input wire logic tie_in,
    // pins toward the sequencer
    output logic wake_out,
    output logic dim_out
);
    // pins follow the requests directly
    assign wake_out = wake_req_in;
    assign dim_out = tie_in ? wake_req_in : dim_req_in;
endmodule : host_model

// ==== sim/led_startup_sequencer_tb.sv ====
// Purpose: self-checking bench for the led startup sequencer
// Assumes: shortened timer parameters keep the run brief
// Notes: channel usage mask comes from a seeded random draw
`timescale 1ns/1ns
module led_startup_sequencer_tb;
    import startup_seq_pkg::*;
    localparam int SHD = 20; // shutdown filter
    localparam int DET = 10; // detection wait
    localparam int SOFT = 30; // soft-start timer
    localparam int CLR = 20; // latch clear filter
    logic clock_in;
    logic srst_in = 1'b1;
    logic supply_ok_in = 1'b0;
    logic wake_req = 1'b0;
    logic dim_req = 1'b0;
    logic tie_req = 1'b0;
    logic wake_in, dim_gate_in;
    power_sense_type ps = 6'h04; // output above undervoltage only
    led_sense_type [5:0] ls = '0;
    logic regulator_on_out, clock_output_en_out, gate_pull_out, current_ref_en_out;
    logic boost_en_out, soft_start_out, fault_n_out, output_undervoltage_fault_out;
    logic [5:0] channel_en_out, mask;
    seq_state_type state_out;
    int seed, waited, cycles, error_cnt, comparisons;
    host_model host_model_inst (.wake_req_in(wake_req), .dim_req_in(dim_req), .tie_in(tie_req),
        .wake_out(wake_in), .dim_out(dim_gate_in));
    led_startup_sequencer #(.SHUTDOWN_CYC(SHD), .DETECT_CYC(DET), .SOFT_CYC(SOFT), .CLEAR_CYC(CLR))
        led_startup_sequencer_inst (.clock_in, .srst_in, .wake_in, .dim_gate_in, .supply_ok_in,
        .power_sense_in(ps), .led_sense_in(ls), .regulator_on_out, .clock_output_en_out, .gate_pull_out,
        .current_ref_en_out, .boost_en_out, .soft_start_out, .channel_en_out, .fault_n_out,
        .output_undervoltage_fault_out, .state_out);
    // 50 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    // hang guard
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask : chk
    task automatic steps(input int n);
        repeat (n) @(negedge clock_in);
    endtask : steps
    // expected enables: channels whose pin sits above both the short level and the in-use level
    function automatic logic [5:0] exp_channels(input led_sense_type [5:0] s);
        exp_channels = 6'h00;
        for (int i = 0; i < 6; i++) exp_channels[i] = s[i].above_short && s[i].above_in_use;
    endfunction : exp_channels
    // bounded wait for a state, dwell kept in waited
    task automatic wait_st(input seq_state_type s, input int lim);
        waited = 0;
        while (state_out !== s && waited < lim) begin
            @(negedge clock_in);
            waited++;
        end
        chk(state_out === s, "state not reached");
    endtask : wait_st
    // wake up to the wait for dimming gate
    task automatic bring_up(input logic [5:0] m, input logic [5:0] s);
        for (int i = 0; i < 6; i++) ls[i] = {s[i], m[i], 1'b0};
        ps.gate_pulled = 1'b0;
        supply_ok_in = 1'b1;
        wake_req = 1'b1;
        wait_st(ST_GATE_PULL, 8);
        chk(regulator_on_out === 1'b1 && clock_output_en_out === 1'b1 && gate_pull_out === 1'b1, "wake outs");
        steps(4);
        ps.gate_pulled = 1'b1;
        wait_st(ST_WAIT_DIM, 8);
        chk(current_ref_en_out === 1'b1, "reference off");
    endtask : bring_up
    task automatic to_soft();
        wait_st(ST_DETECT, 8);
        wait_st(ST_SOFT_START, DET + 12);
        chk(waited >= DET, "detection too short");
    endtask : to_soft
    task automatic power_off(input string n);
        wake_req = 1'b0;
        dim_req = 1'b0;
        wait_st(ST_OFF, SHD + 10);
        chk(waited >= SHD, "shut off too soon");
        $display("test %s done", n);
    endtask : power_off
    // main sequence
    initial begin
        seed = 86;
        steps(2);
        srst_in = 1'b0;
        wake_req = 1'b1;
        steps(10);
        chk(state_out === ST_OFF, "woke without supply");
        mask = 6'($random(seed));
        mask[0] = 1'b1;
        bring_up(mask, 6'h3F);
        steps(10);
        chk(state_out === ST_WAIT_DIM && boost_en_out === 1'b0, "started without dim");
        dim_req = 1'b1;
        to_soft();
        steps(2);
        chk(boost_en_out === 1'b1 && soft_start_out === 1'b1 && channel_en_out === exp_channels(ls), "channels");
        for (int i = 0; i < 6; i++) ls[i].in_regulation = mask[i];
        wait_st(ST_RUN, 8);
        wake_req = 1'b0;
        steps(5);
        wake_req = 1'b1;
        steps(8);
        chk(state_out === ST_RUN, "short wake low shut off");
        ps.frequency_set_pin_fault = 1'b1;
        steps(5);
        chk(fault_n_out === 1'b0, "set pin fault hidden");
        ps.frequency_set_pin_fault = 1'b0;
        power_off("normal");
        bring_up(6'h3F, 6'h3F);
        dim_req = 1'b1;
        to_soft();
        wait_st(ST_RUN, SOFT + 10);
        chk(waited >= SOFT, "soft-start timer short");
        power_off("timer");
        tie_req = 1'b1;
        bring_up(6'h3F, 6'h3B);
        wait_st(ST_DETECT, 8);
        steps(DET + 10);
        chk(state_out === ST_DETECT && fault_n_out === 1'b0, "pin short ignored");
        ls[2].above_short = 1'b1;
        to_soft();
        chk(fault_n_out === 1'b1, "fault not released");
        ps.output_at_93pct = 1'b1;
        wait_st(ST_RUN, 8);
        power_off("short");
        tie_req = 1'b0;
        ps.output_at_93pct = 1'b0;
        ps.current_set_pin_fault = 1'b1;
        bring_up(6'h3F, 6'h3F);
        dim_req = 1'b1;
        steps(DET + 10);
        chk(state_out !== ST_SOFT_START && boost_en_out === 1'b0 && fault_n_out === 1'b0, "set pin");
        ps.current_set_pin_fault = 1'b0;
        wait_st(ST_SOFT_START, DET + 20);
        power_off("setpin");
        bring_up(6'h3F, 6'h3F);
        ps.output_above_uv = 1'b0;
        dim_req = 1'b1;
        wait_st(ST_LATCHED, DET + 20);
        chk(output_undervoltage_fault_out === 1'b1 && boost_en_out === 1'b0, "latch outs");
        dim_req = 1'b0;
        wait_st(ST_GATE_PULL, CLR + 10);
        chk(waited >= CLR && output_undervoltage_fault_out === 1'b0, "dim clear");
        dim_req = 1'b1;
        wait_st(ST_LATCHED, DET + 20);
        supply_ok_in = 1'b0;
        wait_st(ST_OFF, 8);
        supply_ok_in = 1'b1;
        wait_st(ST_LATCHED, DET + 30);
        power_off("latch");
        wrap_up();
    end
endmodule : led_startup_sequencer_tb
